//--- design/tacc_period_timer.sv
// Down-counting period timer that counts sequence strobes after a start.
// Assumes start and tick are one-cycle pulses in the clk domain.

`timescale 1ns/1ps
`default_nettype none

module tacc_period_timer #(
    parameter int W = 10
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Control
    input wire logic start,
    input wire logic [W-1:0] start_value,
    input wire logic tick,
    // Status
    output logic busy,
    output logic expired
);

    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;
    logic last_tick;

    assign last_tick = busy && tick && (cnt_q == W'(1));
    assign cnt_d = start ? start_value : ((busy && tick) ? cnt_q - W'(1) : cnt_q);

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            cnt_q <= '0;
            busy <= 1'b0;
            expired <= 1'b0;
        end
        else
        begin
            cnt_q <= cnt_d;
            busy <= (cnt_d != '0);
            expired <= last_tick && !start;
        end
    end

endmodule

`default_nettype wire

//--- design/tacc_pkg.sv
// Package for the ambient compensation control bank: offsets, fields, resets, timing factors.
// Assumes a 16-bit register port and conversion-sequence strobes from the sequencer.
//
// Function
// - The low four bits of control A set how many sequence results are dropped per result let into the fast FIFO.
// - In full power the calibration is held off for the full-power proximity count times 16 sequences.
// - In low power the calibration is held off for the low-power proximity count times 4 low-power sequences.
// - The timeout field sets the full-to-low power delay as 1.25, 1.50, 1.75 or 2.00 times the full-power count times 16 sequences.
// - While the forced-calibration bit is set every stage is made to recalibrate.
// - Writing one to the restart bit restarts the sequence at the first stage and the bit clears itself.
// - The effective recalibration level is the programmed byte times 16, default 64.
// - The effective detection rate is the six-bit programmed value times 16, default one.
// - The full-power recalibration time is ten bits in control C and resets to 3FF.
// - The low-power recalibration time is the upper six bits of control C and resets to 3F.
// - Each low-interrupt enable bit lets its stage's low-threshold condition assert the interrupt; all reset to zero.
// - The slow filter update level is the top two bits of control B and resets to zero.

package tacc_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [9:0] TACC_ADDR_CTRL_A = 10'h002;
    localparam logic [9:0] TACC_ADDR_CTRL_B = 10'h003;
    localparam logic [9:0] TACC_ADDR_RECAL = 10'h004;
    localparam logic [9:0] TACC_ADDR_LOW_EN = 10'h005;

    // ------------------------------------------------------------
    // Field layouts
    // ------------------------------------------------------------
    typedef struct packed {
        logic sequence_restart;
        logic forced_cal;
        logic [1:0] power_drop_timeout;
        logic [3:0] low_power_prox_count;
        logic [3:0] full_power_prox_count;
        logic [3:0] fast_filter_skip_count;
    } tacc_ctrl_a_s;

    typedef struct packed {
        logic [1:0] slow_filter_update_level;
        logic [5:0] prox_detect_rate;
        logic [7:0] prox_recal_level;
    } tacc_ctrl_b_s;

    typedef struct packed {
        logic [5:0] low_power_recal_time;
        logic [9:0] full_power_recal_time;
    } tacc_recal_s;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [15:0] TACC_RST_CTRL_A = 16'h0FF0;
    localparam logic [15:0] TACC_RST_CTRL_B = 16'h0140;
    localparam logic [15:0] TACC_RST_RECAL = 16'hFFFF;
    localparam logic [15:0] TACC_RST_LOW_EN = 16'h0000;

    // ------------------------------------------------------------
    // Scaling and timing factors
    // ------------------------------------------------------------
    localparam int TACC_FP_SEQ_PER_COUNT = 16;
    localparam int TACC_LP_SEQ_PER_COUNT = 4;
    localparam int TACC_TIMEOUT_QUARTERS_BASE = 5;
    localparam int TACC_LEVEL_SCALE_SHIFT = 4;
    localparam int TACC_TIMER_W = 10;
    localparam int TACC_STAGES = 12;

endpackage

//--- design/tacc_top.sv
// Ambient compensation control bank with its sequence timers and low-threshold interrupt.
// Assumes the serial interface decodes host accesses into single-cycle write and read strobes,
// and the conversion sequencer gives one-cycle strobes at the end of each sequence.

`timescale 1ns/1ps
`default_nettype none

module tacc_top
    import tacc_pkg::*;
#(
    parameter int STAGES = TACC_STAGES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Register port
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [9:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    // Sequencer status
    input wire logic fp_seq_done,
    input wire logic lp_seq_done,
    input wire logic low_power_mode,
    input wire logic prox_active,
    input wire logic [STAGES-1:0] stage_low_exceeded,
    // Compensation controls
    output logic fifo_admit,
    output logic cal_suspend,
    output logic power_drop_req,
    output logic forced_cal,
    output logic restart_first_stage,
    output logic [11:0] prox_recal_level_eff,
    output logic [9:0] prox_detect_rate_eff,
    output logic [1:0] slow_filter_update_level,
    output logic [9:0] full_power_recal_time,
    output logic [5:0] low_power_recal_time,
    // Interrupt pin, active low
    output logic int_n
);

    // ------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------
    tacc_ctrl_a_s ctrl_a_q;
    tacc_ctrl_b_s ctrl_b_q;
    tacc_recal_s recal_q;
    logic [15:0] low_en_q;

    logic wr_a;
    logic wr_b;
    logic wr_c;
    logic wr_en;
    logic [15:0] rd_mux;
    tacc_ctrl_a_s wdata_a;

    assign wdata_a = tacc_ctrl_a_s'(reg_wdata);
    assign wr_a = reg_wr && (reg_addr == TACC_ADDR_CTRL_A);
    assign wr_b = reg_wr && (reg_addr == TACC_ADDR_CTRL_B);
    assign wr_c = reg_wr && (reg_addr == TACC_ADDR_RECAL);
    assign wr_en = reg_wr && (reg_addr == TACC_ADDR_LOW_EN);

    // The restart bit is never stored, so it always reads back as zero.
    assign rd_mux = (reg_addr == TACC_ADDR_CTRL_A) ? {1'b0, 15'(ctrl_a_q)} :
                    (reg_addr == TACC_ADDR_CTRL_B) ? 16'(ctrl_b_q) :
                    (reg_addr == TACC_ADDR_RECAL) ? 16'(recal_q) :
                    (reg_addr == TACC_ADDR_LOW_EN) ? low_en_q : 16'h0000;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            ctrl_a_q <= tacc_ctrl_a_s'(TACC_RST_CTRL_A);
            ctrl_b_q <= tacc_ctrl_b_s'(TACC_RST_CTRL_B);
            recal_q <= tacc_recal_s'(TACC_RST_RECAL);
            low_en_q <= TACC_RST_LOW_EN;
            reg_rdata <= 16'h0000;
        end
        else
        begin
            if (wr_a)
            begin
                ctrl_a_q <= wdata_a;
                ctrl_a_q.sequence_restart <= 1'b0;
            end
            if (wr_b)
                ctrl_b_q <= tacc_ctrl_b_s'(reg_wdata);
            if (wr_c)
                recal_q <= tacc_recal_s'(reg_wdata);
            if (wr_en)
                low_en_q <= reg_wdata;
            if (reg_rd)
                reg_rdata <= rd_mux;
        end
    end

    // ------------------------------------------------------------
    // Fast filter admission
    // ------------------------------------------------------------
    logic [3:0] skip_q;
    logic skip_done;

    assign skip_done = (skip_q >= ctrl_a_q.fast_filter_skip_count);

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            skip_q <= 4'h0;
            fifo_admit <= 1'b0;
        end
        else
        begin
            fifo_admit <= fp_seq_done && skip_done;
            if (fp_seq_done)
                skip_q <= skip_done ? 4'h0 : skip_q + 4'h1;
        end
    end

    // ------------------------------------------------------------
    // Calibration hold-off and power-down timers
    // ------------------------------------------------------------
    logic prox_q;
    logic prox_rise;
    logic fp_start;
    logic lp_start;
    logic fp_busy;
    logic lp_busy;
    logic to_expired;
    logic [TACC_TIMER_W-1:0] fp_period;
    logic [TACC_TIMER_W-1:0] lp_period;
    logic [TACC_TIMER_W-1:0] to_period;

    assign prox_rise = prox_active && !prox_q;
    assign fp_start = prox_rise && !low_power_mode;
    assign lp_start = prox_rise && low_power_mode;
    assign fp_period = TACC_TIMER_W'(ctrl_a_q.full_power_prox_count * TACC_FP_SEQ_PER_COUNT);
    assign lp_period = TACC_TIMER_W'(ctrl_a_q.low_power_prox_count * TACC_LP_SEQ_PER_COUNT);
    assign to_period = TACC_TIMER_W'((ctrl_a_q.full_power_prox_count * TACC_FP_SEQ_PER_COUNT
                       * (TACC_TIMEOUT_QUARTERS_BASE + ctrl_a_q.power_drop_timeout)) / 4);

    tacc_period_timer #(.W(TACC_TIMER_W)) u_fp_hold (
        .clk(clk),
        .rst_n(rst_n),
        .start(fp_start),
        .start_value(fp_period),
        .tick(fp_seq_done),
        .busy(fp_busy),
        .expired()
    );

    tacc_period_timer #(.W(TACC_TIMER_W)) u_lp_hold (
        .clk(clk),
        .rst_n(rst_n),
        .start(lp_start),
        .start_value(lp_period),
        .tick(lp_seq_done),
        .busy(lp_busy),
        .expired()
    );

    // The timeout only runs in full power; proximity restarts it.
    tacc_period_timer #(.W(TACC_TIMER_W)) u_timeout (
        .clk(clk),
        .rst_n(rst_n),
        .start(fp_start),
        .start_value(to_period),
        .tick(fp_seq_done),
        .busy(),
        .expired(to_expired)
    );

    // ------------------------------------------------------------
    // Control outputs and interrupt
    // ------------------------------------------------------------
    logic irq_any;

    assign irq_any = |(low_en_q[STAGES-1:0] & stage_low_exceeded);

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            prox_q <= 1'b0;
            cal_suspend <= 1'b0;
            power_drop_req <= 1'b0;
            forced_cal <= 1'b0;
            restart_first_stage <= 1'b0;
            prox_recal_level_eff <= 12'h000;
            prox_detect_rate_eff <= 10'h000;
            slow_filter_update_level <= 2'h0;
            full_power_recal_time <= 10'h000;
            low_power_recal_time <= 6'h00;
            int_n <= 1'b1;
        end
        else
        begin
            prox_q <= prox_active;
            cal_suspend <= fp_busy || lp_busy || fp_start || lp_start;
            // drop once timeout ends
            // A timeout that ends in the same cycle as a clear still raises the request.
            power_drop_req <= to_expired || (power_drop_req && !prox_rise && !low_power_mode);
            forced_cal <= ctrl_a_q.forced_cal;
            restart_first_stage <= wr_a && wdata_a.sequence_restart;
            prox_recal_level_eff <= {ctrl_b_q.prox_recal_level, 4'h0};
            prox_detect_rate_eff <= {ctrl_b_q.prox_detect_rate, 4'h0};
            slow_filter_update_level <= ctrl_b_q.slow_filter_update_level;
            full_power_recal_time <= recal_q.full_power_recal_time;
            low_power_recal_time <= recal_q.low_power_recal_time;
            int_n <= !irq_any;
        end
    end

endmodule

`default_nettype wire

//--- test/tacc_seq_model.sv
// Conversion sequencer stand-in: issues end-of-sequence strobes on request.
// Assumes the bench raises want to ask for more; spacing varies from 1 to 4 cycles.
`timescale 1ns/1ps
`default_nettype none
module tacc_seq_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Request and mode
    input wire logic [7:0] want,
    input wire logic low_power_mode,
    // Strobes
    output logic fp_seq_done,
    output logic lp_seq_done
);
    logic [7:0] sent_q;
    logic [1:0] gap_q;
    logic fire;
    // Varying gaps mix back-to-back strobes with slow ones, so no fixed cadence is assumed.
    assign fire = rst_n && (gap_q == 2'h0) && (sent_q != want);
    always @(negedge clk)
    begin
        fp_seq_done <= fire && !low_power_mode;
        lp_seq_done <= fire && low_power_mode;
        if (!rst_n)
        begin
            sent_q <= 8'h00;
            gap_q <= 2'h0;
        end
        else if (gap_q != 2'h0)
            gap_q <= gap_q - 2'h1;
        else if (fire)
        begin
            sent_q <= sent_q + 8'h01;
            gap_q <= sent_q[1:0];
        end
    end
endmodule
`default_nettype wire

//--- test/tacc_top_props.sv
// Checker on the ports of tacc_top, attached by bind at the foot of this file.
// Assumes derived outputs follow a register write two clock edges later.
`timescale 1ns/1ps
`default_nettype none
module tacc_top_props
    import tacc_pkg::*;
#(
    parameter int STAGES = TACC_STAGES
) (
    // Clock, reset and register port
    input wire logic clk,
    input wire logic rst_n,
    input wire logic reg_wr,
    input wire logic [9:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    // Sequencer side
    input wire logic fp_seq_done,
    input wire logic prox_active,
    input wire logic [STAGES-1:0] stage_low_exceeded,
    // Outputs
    input wire logic fifo_admit,
    input wire logic cal_suspend,
    input wire logic forced_cal,
    input wire logic restart_first_stage,
    input wire logic [11:0] prox_recal_level_eff,
    input wire logic [9:0] prox_detect_rate_eff,
    input wire logic [1:0] slow_filter_update_level,
    input wire logic [9:0] full_power_recal_time,
    input wire logic [5:0] low_power_recal_time,
    input wire logic int_n
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_wr(logic [9:0] a);
        reg_wr && reg_addr == a;
    endsequence
    chk_level_scale: assert property (s_wr(TACC_ADDR_CTRL_B) |-> ##2
        prox_recal_level_eff == {$past(reg_wdata[7:0], 2), 4'h0}) else $error("recal level wrong");
    chk_rate_scale: assert property (s_wr(TACC_ADDR_CTRL_B) |-> ##2
        prox_detect_rate_eff == {$past(reg_wdata[13:8], 2), 4'h0}) else $error("detect rate wrong");
    chk_slow_level: assert property (s_wr(TACC_ADDR_CTRL_B) |-> ##2
        slow_filter_update_level == $past(reg_wdata[15:14], 2)) else $error("slow level wrong");
    chk_recal_times: assert property (s_wr(TACC_ADDR_RECAL) |-> ##2
        {low_power_recal_time, full_power_recal_time} == $past(reg_wdata, 2)) else $error("times wrong");
    chk_forced_copy: assert property (s_wr(TACC_ADDR_CTRL_A) |-> ##2
        forced_cal == $past(reg_wdata[14], 2)) else $error("forced cal wrong");
    chk_restart_start: assert property (s_wr(TACC_ADDR_CTRL_A) ##0 reg_wdata[15] |=>
        restart_first_stage) else $error("restart missing");
    chk_restart_cause: assert property (restart_first_stage |->
        $past(reg_wr && reg_addr == TACC_ADDR_CTRL_A && reg_wdata[15])) else $error("restart stray");
    chk_admit_cause: assert property (fifo_admit |-> $past(fp_seq_done))
        else $error("admit without sequence");
    chk_suspend_start: assert property ($rose(prox_active) |=> cal_suspend)
        else $error("hold-off missing");
    chk_irq_idle: assert property (stage_low_exceeded == '0 |=> int_n)
        else $error("interrupt without source");
endmodule
bind tacc_top tacc_top_props #(.STAGES(STAGES)) tacc_top_props_i (.clk, .rst_n, .reg_wr, .reg_addr,
    .reg_wdata, .fp_seq_done, .prox_active, .stage_low_exceeded, .fifo_admit, .cal_suspend, .forced_cal,
    .restart_first_stage, .prox_recal_level_eff, .prox_detect_rate_eff, .slow_filter_update_level,
    .full_power_recal_time, .low_power_recal_time, .int_n);
`default_nettype wire

//--- test/tacc_top_tb_top.sv
// Self-checking bench for tacc_top with the sequencer stand-in.
// Assumes strobe register access and one clock; stimulus changes on falling edges.
`timescale 1ns/1ps
`default_nettype none
module tacc_top_tb_top;
    import tacc_pkg::*;
    logic clk = 1'b1;
    logic rst_n = 1'b0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic rd_d = 1'b0;
    logic low_power_mode = 1'b0;
    logic prox_active = 1'b0;
    logic [9:0] reg_addr = 10'h000;
    logic [15:0] reg_wdata = 16'h0000;
    logic [11:0] exc = 12'h000;
    logic [7:0] want = 8'h00;
    logic fp_done, lp_done, admit, susp, drop, fcal, rstrt, int_n;
    logic [15:0] rdata, v, en;
    logic [11:0] lvl;
    logic [9:0] rate, fpt;
    logic [5:0] lpt;
    logic [1:0] sfl;
    logic [3:0] codes[3] = '{4'h0, 4'h1, 4'hB};
    logic [15:0] exp_q[$];
    int err_total = 0;
    int n_tests = 0;
    int n_seq = 0;
    int n_adm = 0;
    int seed = 32'hf53c27e8;
    tacc_top tacc_top_i (.clk, .rst_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata(rdata),
        .fp_seq_done(fp_done), .lp_seq_done(lp_done), .low_power_mode, .prox_active,
        .stage_low_exceeded(exc), .fifo_admit(admit), .cal_suspend(susp), .power_drop_req(drop),
        .forced_cal(fcal), .restart_first_stage(rstrt), .prox_recal_level_eff(lvl),
        .prox_detect_rate_eff(rate), .slow_filter_update_level(sfl), .full_power_recal_time(fpt),
        .low_power_recal_time(lpt), .int_n);
    tacc_seq_model tacc_seq_model_i (.clk, .rst_n, .want, .low_power_mode, .fp_seq_done(fp_done),
        .lp_seq_done(lp_done));
    initial
        forever #10 clk = ~clk;
    always @(posedge clk)
    begin
        rd_d <= reg_rd;
        n_seq <= n_seq + 32'(fp_done | lp_done);
        n_adm <= n_adm + 32'(admit);
    end
    always @(negedge clk)
        if (rd_d)
            chk(rdata, exp_q.pop_front());
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            err_total++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [9:0] a, input logic [15:0] d);
        @(negedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(negedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [9:0] a, input logic [15:0] e);
        @(negedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        exp_q.push_back(e);
        @(negedge clk);
        reg_rd <= 1'b0;
    endtask
    // Asks the stand-in for n strobes, waits until all were seen, then m more cycles.
    task automatic seq(input int n, input int m);
        int tgt;
        tgt = n_seq + n;
        want <= want + 8'(n);
        repeat (300) if (n_seq < tgt) @(negedge clk);
        repeat (m) @(negedge clk);
    endtask
    task automatic give_verdict;
        $display("comparisons %0d, mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (5000) @(posedge clk);
        err_total++;
        give_verdict();
    end
    initial
    begin
        repeat (9) @(negedge clk);
        rst_n <= 1'b1;
        rd(TACC_ADDR_CTRL_A, 16'h0FF0);
        rd(TACC_ADDR_CTRL_B, 16'h0140);
        rd(TACC_ADDR_RECAL, 16'hFFFF);
        rd(TACC_ADDR_LOW_EN, 16'h0000);
        rd(10'h006, 16'h0000);
        chk(16'(lvl), 16'h0400);
        chk(16'(rate), 16'h0010);
        chk({lpt, fpt}, 16'hFFFF);
        $display("test done: reset values");
        for (int i = 0; i < 4; i++)
        begin
            v = 16'($random(seed));
            wr(TACC_ADDR_CTRL_B, v);
            wr(TACC_ADDR_RECAL, ~v);
            wr(10'h006, v);
            rd(TACC_ADDR_CTRL_B, v);
            rd(TACC_ADDR_RECAL, ~v);
            rd(10'h3FF, 16'h0000);
            chk(16'({lvl, sfl}), 16'({v[7:0], 4'h0, v[15:14]}));
            chk(16'(rate), 16'({v[13:8], 4'h0}));
            chk({lpt, fpt}, ~v);
        end
        $display("test done: read and write");
        wr(TACC_ADDR_CTRL_A, 16'hC110);
        chk(16'(rstrt), 16'h0001);
        @(negedge clk);
        chk(16'({rstrt, fcal}), 16'h0001);
        rd(TACC_ADDR_CTRL_A, 16'h4110);
        $display("test done: restart and forced calibration");
        foreach (codes[j])
        begin
            wr(TACC_ADDR_CTRL_A, {12'h011, codes[j]});
            v = 16'(n_adm);
            seq(2 * (int'(codes[j]) + 1), 3);
            chk(16'(n_adm) - v, 16'h0002);
        end
        $display("test done: fast filter skip");
        for (int c = 0; c < 4; c++)
        begin
            wr(TACC_ADDR_CTRL_A, {2'h0, 2'(c), 12'h110});
            low_power_mode <= 1'b0;
            prox_active <= 1'b1;
            repeat (2) @(negedge clk);
            chk(16'(susp), 16'h0001);
            seq(15, 1);
            chk(16'(susp), 16'h0001);
            seq(1, 3);
            chk(16'(susp), 16'h0000);
            seq(3 + 4 * c, 1);
            chk(16'(drop), 16'h0000);
            seq(1, 3);
            chk(16'(drop), 16'h0001);
            prox_active <= 1'b0;
            low_power_mode <= 1'b1;
            repeat (2) @(negedge clk);
            chk(16'(drop), 16'h0000);
        end
        prox_active <= 1'b1;
        repeat (2) @(negedge clk);
        chk(16'(susp), 16'h0001);
        seq(3, 1);
        chk(16'(susp), 16'h0001);
        seq(1, 3);
        chk(16'(susp), 16'h0000);
        $display("test done: hold-off and timeout");
        for (int i = 0; i < 8; i++)
        begin
            en = 16'($random(seed));
            wr(TACC_ADDR_LOW_EN, en);
            exc <= 12'($random(seed)) & (i[0] ? 12'hFFF : ~en[11:0]);
            repeat (2) @(negedge clk);
            chk(16'(int_n), 16'(!(|(en[11:0] & exc))));
            rd(TACC_ADDR_LOW_EN, en);
        end
        $display("test done: low-threshold interrupt");
        give_verdict();
    end
endmodule
`default_nettype wire
